// file: strc_pkg.sv
// Shared constants and carrier types for the system tick reload and live-count block.
package strc_pkg;

   // Width of the counter and of the register data path.
   localparam int unsigned COUNT_W = 24;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned ADDR_W  = 8;

   // Register byte offsets within the timer window.
   localparam logic [7:0] OFS_CTRL    = 8'h10;  // Control/status, kept outside this block.
   localparam logic [7:0] OFS_RESTART = 8'h14;  // Restart value.
   localparam logic [7:0] OFS_LIVE    = 8'h18;  // Live count.
   localparam logic [7:0] OFS_CALIB   = 8'h1c;  // Calibration slot, not implemented.

   // Field positions of the count fields.
   localparam int unsigned COUNT_LSB = 0;
   localparam int unsigned COUNT_MSB = 23;

   // Reset values.
   localparam logic [23:0] RESTART_RST = 24'h000000;
   localparam logic [23:0] LIVE_RST    = 24'h000000;
   localparam logic [31:0] RDATA_RST   = 32'h00000000;

   // One register access request, sampled on a clock edge.
   typedef struct packed {
      logic        wr;     // Write strobe, one cycle.
      logic        rd;     // Read strobe, one cycle.
      logic [7:0]  addr;   // Byte offset.
      logic [31:0] wdata;  // Write data.
   } strc_req_t;

   // Timer control levels supplied by the control/status register.
   typedef struct packed {
      logic enable;        // Counter runs while high.
      logic tick_irq_en;   // Zero events pend the tick exception.
   } strc_ctrl_t;

endpackage

// file: strc_counter.sv
// Down counter with wrap-to-restart, clear and zero-event detection.
`timescale 1ns/1ns
module strc_counter #(
   parameter int unsigned WIDTH = 24
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             resetn,
   // Control.
   input  wire logic             enable,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] restart,
   // State.
   output logic      [WIDTH-1:0] count,
   output logic                  zero_evt
);

   // Elaboration check: the count must hold at least one bit and fit the data word.
   if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("strc_counter: WIDTH must be 1 to 32.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-count selection.

   wire logic             at_zero;     // Count has reached zero.
   wire logic             at_one;      // Count will reach zero on this step.
   wire logic [WIDTH-1:0] next_count;  // Value taken on the next edge.

   assign at_zero = (count == '0);
   assign at_one  = (count == WIDTH'(1));

   // A clear beats counting, so the write always lands; the restart register is
   // only looked at when the count sits at zero, so rewriting it never disturbs
   // a count already in progress. A zero restart simply leaves the count at zero.
   assign next_count = clear             ? '0 :
                       !enable           ? count :
                       at_zero           ? restart :
                       count - WIDTH'(1);

   // The event belongs to the step from one to zero; a clear suppresses it.
   assign zero_evt = enable && !clear && at_one;

   ////////////////////////////////////////////////////////////////////////////////
   // Count register.

   // The live count, reset to zero.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

// file: strc_tick.sv
// Restart-value and live-count registers of the system tick timer.
//
// How it works
// - Hold restart value, reload count at zero.
// - Repeating period is restart plus one clocks.
// - Zero restart: no event, no flag.
// - Upper eight bits reserved, read as zero.
// - Live read returns count at access time.
// - No read-modify-write protection on live count.
// - Any live-count write clears count to zero.
// - Live-count write also clears zero flag.
// - No calibration register; slot reads zero.
// - Decrement each clock, reload after zero.
// - Zero sets flag; pend if enabled.
// - Zero restart stops counter at wrap.
// - Clearing write never pends the exception.
`timescale 1ns/1ns
module strc_tick #(
   parameter int unsigned WIDTH = 24
) (
   // Clock and reset.
   input  wire logic                   clock,
   input  wire logic                   resetn,
   // Register access.
   input  wire strc_pkg::strc_req_t    req,
   output logic [31:0]                 rdata,
   // Control levels and flag read-clear.
   input  wire strc_pkg::strc_ctrl_t   ctrl,
   input  wire logic                   flag_rd_clr,
   // Status to the control/status register and the exception logic.
   output logic                        zero_reached_flag,
   output logic                        tick_pend
);

   // Elaboration check: the register layout fixes the count at the documented width.
   if (WIDTH != strc_pkg::COUNT_W) begin : g_bad_width
      $error("strc_tick: WIDTH must equal the 24-bit count field.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode.

   wire logic wr_restart;  // Write to the restart register.
   wire logic wr_live;     // Write to the live-count register.
   wire logic rd_restart;  // Read of the restart register.
   wire logic rd_live;     // Read of the live-count register.

   assign wr_restart = req.wr && (req.addr == strc_pkg::OFS_RESTART);
   assign wr_live    = req.wr && (req.addr == strc_pkg::OFS_LIVE);
   assign rd_restart = req.rd && (req.addr == strc_pkg::OFS_RESTART);
   assign rd_live    = req.rd && (req.addr == strc_pkg::OFS_LIVE);

   ////////////////////////////////////////////////////////////////////////////////
   // Restart value register.

   logic [WIDTH-1:0] restart;  // Value loaded into the count at each wrap.

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         restart <= strc_pkg::RESTART_RST;
      end else if (wr_restart) begin
         restart <= req.wdata[strc_pkg::COUNT_MSB:strc_pkg::COUNT_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter.

   wire logic [WIDTH-1:0] count;     // Live count.
   wire logic             zero_evt;  // One-to-zero step this cycle.

   strc_counter #(
      .WIDTH    (WIDTH)
   ) u_counter (
      .clock    (clock),
      .resetn   (resetn),
      .enable   (ctrl.enable),
      .clear    (wr_live),
      .restart  (restart),
      .count    (count),
      .zero_evt (zero_evt)
   );

   // no write protection
   // A live-count write lands whatever the counter is doing; software that reads,
   // edits and writes back simply clears the count, as the hardware offers no lock.

   ////////////////////////////////////////////////////////////////////////////////
   // Zero-reached flag and exception pend.

   wire logic next_flag;  // Flag value for the next edge.
   wire logic next_pend;  // Pend pulse for the next edge.

   // live write clears flag
   // A zero step in the same cycle as a read-clear keeps the flag set, so no
   // event is lost; a live write suppresses the step itself in the counter.
   assign next_flag = zero_evt || (zero_reached_flag && !flag_rd_clr && !wr_live);

   assign next_pend = zero_evt && ctrl.tick_irq_en;

   // Flag and pend registers.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         zero_reached_flag <= 1'b0;
         tick_pend         <= 1'b0;
      end else begin
         zero_reached_flag <= next_flag;
         tick_pend         <= next_pend;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   wire logic [31:0] next_rdata;  // Word returned for this access.

   // calibration reads zero
   // Anything other than the two registers, including the calibration slot,
   // answers with zero; the control/status word is served elsewhere.
   assign next_rdata = rd_live    ? {8'h00, count}   :
                       rd_restart ? {8'h00, restart} :
                       strc_pkg::RDATA_RST;

   // Read data register, updated on read strobes only.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rdata <= strc_pkg::RDATA_RST;
      end else if (req.rd) begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // Helper: cycles since the last zero step, and whether the run was undisturbed.
   logic [24:0] gap;    // Cycles since the previous zero step.
   logic        clean;  // No write, stall or restart change since then.
   logic        primed; // At least one zero step seen.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         gap    <= 25'h0000000;
         clean  <= 1'b0;
         primed <= 1'b0;
      end else if (zero_evt) begin
         gap    <= 25'h0000001;
         clean  <= 1'b1;
         primed <= 1'b1;
      end else begin
         gap    <= gap + 25'h0000001;
         clean  <= clean && ctrl.enable && !wr_live && !wr_restart;
      end
   end

   sequence s_wrap;
      ctrl.enable && (count == '0) && !wr_live;
   endsequence

   property p_reload;
      s_wrap |=> (count == $past(restart));
   endproperty
   a_reload: assert property (p_reload) else $error("Count did not reload.");

   property p_period;
      zero_evt && primed && clean && ctrl.enable && !wr_live
         |-> (gap == {1'b0, restart} + 25'h0000001);
   endproperty
   a_period: assert property (p_period) else $error("Tick period wrong.");

   property p_zero_restart;
      (restart == '0) && (count == '0) && !wr_restart ##1 !wr_live
         |-> (count == '0) && !zero_evt;
   endproperty
   a_zero_restart: assert property (p_zero_restart) else $error("Zero restart moved.");

   property p_no_event_zero;
      (count == '0) |-> !zero_evt ##1 !tick_pend;
   endproperty
   a_no_event_zero: assert property (p_no_event_zero) else $error("Event without 1-to-0.");

   property p_live_read;
      rd_live |=> (rdata == {8'h00, $past(count)});
   endproperty
   a_live_read: assert property (p_live_read) else $error("Live read mismatch.");

   property p_live_clear;
      wr_live |=> (count == '0) && !zero_reached_flag && !tick_pend;
   endproperty
   a_live_clear: assert property (p_live_clear) else $error("Live write not cleared.");

   property p_flag_pend;
      zero_evt |=> zero_reached_flag && (tick_pend == $past(ctrl.tick_irq_en));
   endproperty
   a_flag_pend: assert property (p_flag_pend) else $error("Flag or pend missing.");

   property p_decrement;
      ctrl.enable && (count != '0) && !wr_live |=> (count == $past(count) - WIDTH'(1));
   endproperty
   a_decrement: assert property (p_decrement) else $error("Count did not step.");

   property p_calib;
      req.rd && (req.addr == strc_pkg::OFS_CALIB) |=> (rdata == 32'h00000000);
   endproperty
   a_calib: assert property (p_calib) else $error("Calibration slot not zero.");

   property p_reserved;
      req.rd |=> (rdata[31:24] == 8'h00);
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved bits nonzero.");

endmodule

// file: strc_testbench.sv
// Self-checking testbench for the tick restart and live-count registers.
`timescale 1ns/1ns
module testbench;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Signals, notes and counters.
   logic                    clock;              // Bench clock, 100 MHz.
   logic                    resetn;             // Asynchronous reset, active low.
   strc_pkg::strc_req_t     req;                // Register request to the block.
   strc_pkg::strc_ctrl_t    ctrl;               // Enable and interrupt-enable levels.
   logic                    flag_rd_clr;        // Read-clear pulse for the flag.
   logic [31:0]             rdata;              // Read data from the block.
   logic                    zero_reached_flag;  // Sticky zero flag.
   logic                    tick_pend;          // Exception pend pulse.
   logic                    rd_d;               // A read was taken at the last edge.
   logic [31:0]             exp_q[$];           // Expected read data, oldest first.
   logic [31:0]             wd;                 // Random write data.
   int                      seed;               // Random seed.
   int                      fails;              // Mismatches seen.
   int                      comparisons;        // Comparisons made.
   int                      n;                  // Measured cycle count.
   int                      n_rst;              // First restart value.
   int                      m_rst;              // Second restart value.

   strc_tick strc_tick_inst (
      .clock             (clock),
      .resetn            (resetn),
      .req               (req),
      .rdata             (rdata),
      .ctrl              (ctrl),
      .flag_rd_clr       (flag_rd_clr),
      .zero_reached_flag (zero_reached_flag),
      .tick_pend         (tick_pend)
   );

   // The clock inverts every half period.
   always #5 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Shared tasks.
   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One write, held for exactly one rising edge.
   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      req.wr    = 1'b1;
      req.addr  = addr;
      req.wdata = data;
      @(negedge clock);
      req.wr = 1'b0;
   endtask

   // One read; the expectation goes into the queue for the monitor.
   // Back-to-back reads need one idle edge between calls, so the strobe is never
   // lowered and raised again in the same time step.
   task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
      req.rd   = 1'b1;
      req.addr = addr;
      exp_q.push_back(exp);
      @(negedge clock);
      req.rd = 1'b0;
   endtask

   // Counts falling edges until the next pend pulse, bounded so a dead counter cannot hang.
   task automatic wait_pend(output int cnt);
      cnt = 0;
      do begin
         @(negedge clock);
         cnt++;
      end while (tick_pend !== 1'b1 && cnt < 100);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read monitor: read data lands one edge after the read, so it is checked at the next fall.
   always @(posedge clock) begin
      rd_d <= req.rd;
   end

   always @(negedge clock) begin
      if (rd_d === 1'b1) begin
         check("rdata", rdata, exp_q.pop_front());
      end
   end

   // Watchdog; the whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      seed = 74081;
      clock = 1'b0;
      resetn = 1'b0;
      req = '0;
      ctrl = '0;
      flag_rd_clr = 1'b0;
      fails = 0;
      comparisons = 0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      // Reset values, the empty calibration slot and an unmapped offset all read zero.
      rd(strc_pkg::OFS_RESTART, strc_pkg::RDATA_RST);
      @(negedge clock);
      rd(strc_pkg::OFS_LIVE, strc_pkg::RDATA_RST);
      @(negedge clock);
      rd(strc_pkg::OFS_CALIB, 32'h00000000);
      @(negedge clock);
      rd(8'h20, 32'h00000000);
      // A zero restart value runs without events.
      ctrl.enable = 1'b1;
      ctrl.tick_irq_en = 1'b1;
      repeat (20) begin
         @(negedge clock);
         check("tick_pend", {31'h0, tick_pend}, 32'h0);
      end
      check("flag", {31'h0, zero_reached_flag}, 32'h0);
      // Restart value with random reserved bits; they read back as zero.
      n_rst = 4 + ($random(seed) & 7);
      m_rst = 2 + ($random(seed) & 7);
      wd = $random(seed);
      wr(strc_pkg::OFS_RESTART, {wd[31:24], n_rst[23:0]});
      rd(strc_pkg::OFS_RESTART, {8'h00, n_rst[23:0]});
      wait_pend(n);
      wait_pend(n);
      check("period", n, n_rst + 1);
      check("flag", {31'h0, zero_reached_flag}, 32'h1);
      // Live read two edges after the event sees restart minus one.
      @(negedge clock);
      @(negedge clock);
      rd(strc_pkg::OFS_LIVE, {8'h00, 24'(n_rst - 1)});
      // A new restart value leaves the running period alone.
      wr(strc_pkg::OFS_RESTART, m_rst);
      wait_pend(n);
      check("rest_of_period", n, n_rst - 3);
      wait_pend(n);
      check("new_period", n, m_rst + 1);
      // A live write clears count and flag and pends nothing.
      @(negedge clock);
      wd = $random(seed);
      wr(strc_pkg::OFS_LIVE, wd);
      check("flag", {31'h0, zero_reached_flag}, 32'h0);
      check("tick_pend", {31'h0, tick_pend}, 32'h0);
      rd(strc_pkg::OFS_LIVE, 32'h00000000);
      wait_pend(n);
      check("after_clear", n, m_rst);
      // With the interrupt disabled the flag still sets and read-clear drops it.
      ctrl.tick_irq_en = 1'b0;
      flag_rd_clr = 1'b1;
      @(negedge clock);
      flag_rd_clr = 1'b0;
      check("flag", {31'h0, zero_reached_flag}, 32'h0);
      repeat (m_rst) begin
         @(negedge clock);
         check("tick_pend", {31'h0, tick_pend}, 32'h0);
      end
      check("flag", {31'h0, zero_reached_flag}, 32'h1);
      // A zero restart stops the counter at its next wrap.
      @(negedge clock);
      wr(strc_pkg::OFS_RESTART, 32'h00000000);
      repeat (m_rst + 4) @(negedge clock);
      flag_rd_clr = 1'b1;
      @(negedge clock);
      flag_rd_clr = 1'b0;
      ctrl.tick_irq_en = 1'b1;
      repeat (10) begin
         @(negedge clock);
         check("tick_pend", {31'h0, tick_pend}, 32'h0);
      end
      check("flag", {31'h0, zero_reached_flag}, 32'h0);
      rd(strc_pkg::OFS_LIVE, 32'h00000000);
      // A new restart value wakes the stopped counter; with enable low the count holds.
      @(negedge clock);
      wr(strc_pkg::OFS_RESTART, n_rst);
      @(negedge clock);
      ctrl.enable = 1'b0;
      repeat (5) @(negedge clock);
      rd(strc_pkg::OFS_LIVE, {8'h00, n_rst[23:0]});
      @(negedge clock);
      @(negedge clock);
      tally_and_finish();
   end

endmodule
